//--- pkg/mcb_pkg.sv
// package of the modulator configuration register bank: offsets, reset values,
// serial frame layout, state type and the address decoder.
// assumes: imported whole by every design file of the bank.
package mcb_pkg;

  // serial frame: r/w bit, 7 address bits, 16 data bits, msb first
  localparam int MCB_FRAME_BITS = 24;
  localparam logic [4:0] MCB_CNT_ADDR_DONE = 5'h08;
  localparam logic [4:0] MCB_CNT_FRAME_DONE = 5'h18;
  // least sclk high and low time, in clk_sys_i cycles
  localparam int MCB_SCLK_MIN_HALF_CYC = 4;

  // directly held registers
  localparam logic [6:0] MCB_OFS_SOFT_RESET = 7'h00;
  localparam logic [6:0] MCB_OFS_BLOCK_ENABLE = 7'h01;
  localparam logic [15:0] MCB_RST_SOFT_RESET = 16'h0000;
  localparam logic [15:0] MCB_RST_BLOCK_ENABLE = 16'hF67F;
  localparam int MCB_SOFT_RESET_BIT = 0;

  // block enable bit positions
  localparam int MCB_BIT_LO_SINGLE_OSC = 11;
  localparam int MCB_BIT_MOD_CHAIN = 10;
  localparam int MCB_BIT_QUAD_DIV = 9;
  localparam int MCB_BIT_EXT_LO_DOUBLE = 8;
  localparam int MCB_BIT_EXT_LO_SINGLE = 7;
  localparam int MCB_BIT_OSC_MUX = 6;
  localparam int MCB_BIT_REF_BUF = 5;
  localparam int MCB_BIT_OSC = 4;
  localparam int MCB_BIT_OSC_DIV = 3;
  localparam int MCB_BIT_CHARGE_PUMP = 2;
  localparam int MCB_BIT_OSC_REG = 1;

  // memory slots, in this order: pll integer divider, pll fraction, pll modulus,
  // enable gate, charge pump, phase detector, oscillator, balun, linearity,
  // phase tuning, offset tuning, detector pump timing, dither, dither seed,
  // band select, calibration sets
  localparam int MCB_MEM_DEPTH = 16;
  localparam logic [6:0] MCB_SLOT_OFS [MCB_MEM_DEPTH] = '{
    7'h02, 7'h03, 7'h04, 7'h10, 7'h20, 7'h21, 7'h22, 7'h30,
    7'h31, 7'h32, 7'h33, 7'h40, 7'h42, 7'h43, 7'h45, 7'h49};
  localparam logic [15:0] MCB_SLOT_RST [MCB_MEM_DEPTH] = '{
    16'h002C, 16'h0128, 16'h0600, 16'hF67F, 16'h0C26, 16'h000B, 16'h2A03, 16'h0000,
    16'h1101, 16'h0900, 16'h0000, 16'h0010, 16'h000E, 16'h0000, 16'h0000, 16'h16BD};

  // frame state, gray coded along idle, addr, data, done
  typedef enum logic [1:0] {
    MCB_IDLE = 2'h0,
    MCB_ADDR = 2'h1,
    MCB_DATA = 2'h3,
    MCB_DONE = 2'h2
  } mcb_state_t;

  // address to memory slot: bit 4 is the hit flag, bits 3:0 the slot
  function automatic logic [4:0] mcb_slot(input logic [6:0] addr);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < MCB_MEM_DEPTH; i++) begin
      if (MCB_SLOT_OFS[i] == addr) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction

endpackage

//--- test/tb_top.sv
// testbench of the modulator configuration register bank: serial writes and reads,
// register defaults, block enable pins, soft reset, an aborted frame and a mid-run reset.
// assumes: mcb_pkg and the design files are compiled first; the bench plays the serial master.
`timescale 1ns/1ns
`default_nettype none
module tb_top import mcb_pkg::*;;
  typedef struct packed {
    logic [6:0] addr;
    logic [15:0] wdata;
    logic [15:0] exp;
  } mcb_row_t;

  // clock, reset and serial pins
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic sclk_i = 1'b0;
  logic csb_n_i = 1'b1;
  logic tb_sdio = 1'b0;
  logic sdio_o;
  logic sdio_oe_o;
  wire logic sdio_i;
  logic lo1, modc, quad, ext2, ext1, mux, refb, osc, odiv, cp, oreg, soft_reset_o;
  wire logic [15:0] pins = {4'h0, lo1, modc, quad, ext2, ext1, mux, refb, osc, odiv, cp, oreg, 1'b0};
  int errors = 0;
  int total_checks = 0;
  int pulse_cnt = 0;
  logic [15:0] rd;

  // every register offset with its value after reset
  logic [6:0] def_addr [18] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h10, 7'h20, 7'h21, 7'h22,
    7'h30, 7'h31, 7'h32, 7'h33, 7'h40, 7'h42, 7'h43, 7'h45, 7'h49};
  logic [15:0] def_val [18] = '{16'h0000, 16'hF67F, 16'h002C, 16'h0128, 16'h0600, 16'hF67F,
    16'h0C26, 16'h000B, 16'h2A03, 16'h0000, 16'h1101, 16'h0900, 16'h0000, 16'h0010, 16'h000E,
    16'h0000, 16'h0000, 16'h16BD};

  // ordinary cases: write, then expected read back
  mcb_row_t rows [11] = '{
    '{7'h01, 16'h0980, 16'h0980}, '{7'h01, 16'hFFFF, 16'hFFFF}, '{7'h01, 16'h0000, 16'h0000},
    '{7'h01, 16'h0402, 16'h0402}, '{7'h02, 16'hA5A5, 16'hA5A5}, '{7'h03, 16'h5A5A, 16'h5A5A},
    '{7'h10, 16'h1234, 16'h1234}, '{7'h49, 16'hFFFF, 16'hFFFF}, '{7'h05, 16'hBEEF, 16'h0000},
    '{7'h7F, 16'hC3C3, 16'h0000}, '{7'h00, 16'hFFFE, 16'h0000}};

  // the sdio wire as seen by the device: its own drive wins while enabled
  assign sdio_i = sdio_oe_o ? sdio_o : tb_sdio;

  always #50 clk_sys_i = ~clk_sys_i;

  // counts the soft reset pulses, sampled mid-cycle so the launching edge cannot race the count
  always @(negedge clk_sys_i) begin
    if (soft_reset_o === 1'b1) begin
      pulse_cnt++;
    end
  end

  mcb_reg_bank dut (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .sclk_i(sclk_i),
    .csb_n_i(csb_n_i),
    .sdio_i(sdio_i),
    .sdio_o(sdio_o),
    .sdio_oe_o(sdio_oe_o),
    .lo_single_rate_from_osc_enable_o(lo1),
    .modulator_chain_enable_o(modc),
    .quad_divider_enable_o(quad),
    .ext_lo_double_rate_driver_enable_o(ext2),
    .ext_lo_single_rate_driver_enable_o(ext1),
    .oscillator_mux_enable_o(mux),
    .reference_buffer_enable_o(refb),
    .oscillator_enable_o(osc),
    .oscillator_divider_enable_o(odiv),
    .charge_pump_enable_o(cp),
    .oscillator_regulator_enable_o(oreg),
    .soft_reset_o(soft_reset_o)
  );

  // waits n rising edges, then a fixed small delay before inputs change
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #10;
  endtask

  // one serial frame of nbits bits, msb first; read data collected before each rise from bit 8 on
  task automatic frame(input logic rw, input logic [6:0] addr, input logic [15:0] data,
                       input int nbits, output logic [15:0] rdata);
    logic [23:0] word;
    word = {rw, addr, data};
    rdata = 16'h0000;
    csb_n_i = 1'b0;
    tick(5);
    for (int i = 0; i < nbits; i++) begin
      tb_sdio = word[23 - i];
      tick(5);
      if (i >= 8) begin
        rdata = {rdata[14:0], sdio_i};
      end
      sclk_i = 1'b1;
      tick(5);
      sclk_i = 1'b0;
    end
    tick(5);
    csb_n_i = 1'b1;
    tb_sdio = ~tb_sdio;
    tick(4);
  endtask

  task automatic wr(input logic [6:0] addr, input logic [15:0] data);
    logic [15:0] dummy;
    frame(1'b0, addr, data, 24, dummy);
  endtask

  task automatic rdw(input logic [6:0] addr, output logic [15:0] data);
    frame(1'b1, addr, 16'h0000, 24, data);
  endtask

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // enable pins carry bits 11 to 1 of the block enable word
  task automatic check_pins(input logic [15:0] exp);
    total_checks++;
    if (pins !== (exp & 16'h0FFE)) begin
      errors++;
      $display("unexpected at %0t: enable pins %h expected %h", $time, pins, exp & 16'h0FFE);
    end
  endtask

  // reads every register and compares with its value after reset
  task automatic check_defaults();
    for (int i = 0; i < 18; i++) begin
      rdw(def_addr[i], rd);
      check_word(rd, def_val[i], "default value");
    end
    check_pins(16'hF67F);
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog: the tests need roughly 17000 cycles
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    errors++;
    $display("unexpected at %0t: run did not finish", $time);
    close_out();
  end

  initial begin
    int p0;
    tick(8);
    rst_i = 1'b0;
    tick(1);
    check_defaults();
    $display("test defaults done");

    for (int i = 0; i < 11; i++) begin
      p0 = pulse_cnt;
      wr(rows[i].addr, rows[i].wdata);
      if (rows[i].addr == 7'h01) begin
        check_pins(rows[i].exp);
      end
      rdw(rows[i].addr, rd);
      check_word(rd, rows[i].exp, "read back");
      check_word(16'(pulse_cnt - p0), 16'h0000, "soft reset pulses");
    end
    check_word({15'h0000, sdio_oe_o}, 16'h0000, "sdio released");
    $display("test table done");

    // soft reset after several registers were changed
    wr(7'h01, 16'h0980);
    wr(7'h33, 16'hABCD);
    p0 = pulse_cnt;
    wr(7'h00, 16'h0001);
    check_word(16'(pulse_cnt - p0), 16'h0001, "soft reset pulses");
    check_defaults();
    check_word(16'(pulse_cnt - p0), 16'h0001, "soft reset self clear");
    $display("test soft reset done");

    // frame cut short after 16 bits writes nothing
    frame(1'b0, 7'h01, 16'h0800, 16, rd);
    check_pins(16'hF67F);
    rdw(7'h01, rd);
    check_word(rd, 16'hF67F, "aborted write");
    $display("test aborted frame done");

    // reset in mid run restores the defaults
    wr(7'h01, 16'h0000);
    wr(7'h43, 16'h5555);
    rst_i = 1'b1;
    tick(2);
    check_pins(16'hF67F);
    rst_i = 1'b0;
    tick(1);
    rdw(7'h43, rd);
    check_word(rd, 16'h0000, "reset memory");
    rdw(7'h01, rd);
    check_word(rd, 16'hF67F, "reset enables");
    $display("test mid-run reset done");
    close_out();
  end
endmodule // tb_top
`default_nettype wire

//--- verilog/mcb_reg_bank.sv
// top of the modulator configuration register bank: three-wire serial access,
// soft reset, block enable register and the plain configuration memory.
// assumes: serial pins synchronous to clk_sys_i, sclk half periods of at least
// four clk_sys_i cycles, the pad combines sdio_o and sdio_oe_o with sdio_i.
//
// How it works
// - The soft reset control sits at address 0x00 and reads back 0x0000.
// - Only bit 0 of the soft reset word acts, it is write only, bits 15 to 1 do nothing.
// - The block enable word sits at 0x01, is read-write and comes up as 0xF67F.
// - Bit 11 turns on the single-rate LO path from the internal oscillator, off after reset.
// - Bit 10 turns on the modulator and its LO drive chain, on after reset.
// - Bit 9 turns on the quadrature divider for double-rate LO use, on after reset.
// - Bit 8 turns on the external double-rate LO driver ahead of the divider, off after reset.
// - Bit 7 turns on the external single-rate LO driver after the divider, off after reset.
// - Bits 6 to 1 enable mux, reference buffer, oscillators, dividers, pump, regulator, all on.
`timescale 1ns/1ns
`default_nettype none
module mcb_reg_bank import mcb_pkg::*; (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // three-wire serial port
  input wire logic sclk_i,
  input wire logic csb_n_i,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_o,
  // block enables
  output logic lo_single_rate_from_osc_enable_o,
  output logic modulator_chain_enable_o,
  output logic quad_divider_enable_o,
  output logic ext_lo_double_rate_driver_enable_o,
  output logic ext_lo_single_rate_driver_enable_o,
  output logic oscillator_mux_enable_o,
  output logic reference_buffer_enable_o,
  output logic oscillator_enable_o,
  output logic oscillator_divider_enable_o,
  output logic charge_pump_enable_o,
  output logic oscillator_regulator_enable_o,
  // soft reset pulse
  output logic soft_reset_o
);

  // front end view
  logic sclk_rise;
  logic sclk_fall;
  logic [4:0] bit_cnt;
  logic [23:0] shift_w;

  // frame state
  mcb_state_t state_reg;
  mcb_state_t state_next;
  logic rw_reg;
  logic [6:0] addr_reg;
  logic load_reg;

  // read back shifter and pin drivers
  logic [15:0] shout_reg;
  logic [15:0] shout_next;
  logic sdio_reg;
  logic sdio_next;
  logic sdio_oe_reg;
  logic sdio_oe_next;

  // control registers
  logic soft_rst_reg;
  logic [15:0] block_enable_reg;
  logic [15:0] block_enable_next;

  // memory ports
  logic [15:0] mem_rdata;

  // serial front end
  mcb_spi_shift u_shift (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .sclk_i(sclk_i),
    .csb_n_i(csb_n_i),
    .sdio_i(sdio_i),
    .sclk_rise_o(sclk_rise),
    .sclk_fall_o(sclk_fall),
    .bit_cnt_o(bit_cnt),
    .shift_o(shift_w)
  );

  // frame decode
  wire logic addr_done = (bit_cnt == MCB_CNT_ADDR_DONE);
  wire logic frame_done = (bit_cnt == MCB_CNT_FRAME_DONE);
  wire logic frame_rd = shift_w[7];
  wire logic [6:0] frame_addr = shift_w[6:0];
  wire logic [15:0] frame_data = shift_w[15:0];
  wire logic [4:0] new_slot = mcb_slot(frame_addr);
  wire logic [4:0] cur_slot = mcb_slot(addr_reg);

  // write and read strobes, one cycle each
  wire logic wr_frame = (state_reg == MCB_DATA) && frame_done && !rw_reg;
  wire logic wr_soft = wr_frame && (addr_reg == MCB_OFS_SOFT_RESET)
                       && frame_data[MCB_SOFT_RESET_BIT];
  wire logic wr_enable = wr_frame && (addr_reg == MCB_OFS_BLOCK_ENABLE);
  wire logic wr_mem = wr_frame && cur_slot[4];
  wire logic rd_start = (state_reg == MCB_ADDR) && addr_done && frame_rd;
  wire logic rd_mem = rd_start && new_slot[4];

  // read data select; soft reset and unmapped addresses read zero
  wire logic [15:0] rd_word =
    (addr_reg == MCB_OFS_SOFT_RESET) ? MCB_RST_SOFT_RESET :
    (addr_reg == MCB_OFS_BLOCK_ENABLE) ? block_enable_reg :
    cur_slot[4] ? mem_rdata : 16'h0000;

  // plain configuration registers
  mcb_reg_mem u_mem (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .clear_i(soft_rst_reg),
    .wr_en_i(wr_mem),
    .wr_idx_i(cur_slot[3:0]),
    .wr_data_i(frame_data),
    .rd_en_i(rd_mem),
    .rd_idx_i(new_slot[3:0]),
    .rd_data_o(mem_rdata)
  );

  // frame state sequence; chip select high always returns to idle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MCB_IDLE: begin
        if (!csb_n_i) begin
          state_next = MCB_ADDR;
        end
      end
      MCB_ADDR: begin
        if (addr_done) begin
          state_next = MCB_DATA;
        end
      end
      MCB_DATA: begin
        if (frame_done) begin
          state_next = MCB_DONE;
        end
      end
      MCB_DONE: begin
        state_next = MCB_DONE;
      end
      default: begin
        state_next = MCB_IDLE;
      end
    endcase
    if (csb_n_i) begin
      state_next = MCB_IDLE;
    end
  end

  // read back: load first, then one bit per falling sclk edge
  assign shout_next = load_reg ? rd_word :
                      (sclk_fall && rw_reg && state_reg == MCB_DATA) ? {shout_reg[14:0], 1'b0} :
                      shout_reg;
  assign sdio_next = (!load_reg && sclk_fall && rw_reg && state_reg == MCB_DATA) ? shout_reg[15] :
                     (csb_n_i ? 1'b0 : sdio_reg);
  assign sdio_oe_next = csb_n_i ? 1'b0 :
                        (!load_reg && sclk_fall && rw_reg && state_reg == MCB_DATA) ? 1'b1 :
                        sdio_oe_reg;

  // block enable word: written by the frame, reloaded by either reset
  assign block_enable_next = wr_enable ? frame_data : block_enable_reg;

  // frame control registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_reg <= MCB_IDLE;
      rw_reg <= 1'b0;
      addr_reg <= 7'h00;
      load_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if ((state_reg == MCB_ADDR) && addr_done) begin
        rw_reg <= frame_rd;
        addr_reg <= frame_addr;
      end
      load_reg <= rd_start;
    end
  end

  // pin drivers and read shifter
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      shout_reg <= 16'h0000;
      sdio_reg <= 1'b0;
      sdio_oe_reg <= 1'b0;
    end else begin
      shout_reg <= shout_next;
      sdio_reg <= sdio_next;
      sdio_oe_reg <= sdio_oe_next;
    end
  end

  // soft reset pulse clears itself the next cycle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= wr_soft;
    end
  end

  // block enable register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || soft_rst_reg) begin
      block_enable_reg <= MCB_RST_BLOCK_ENABLE;
    end else begin
      block_enable_reg <= block_enable_next;
    end
  end

  // outputs, each a flip-flop bit
  assign sdio_o = sdio_reg;
  assign sdio_oe_o = sdio_oe_reg;
  assign soft_reset_o = soft_rst_reg;
  assign lo_single_rate_from_osc_enable_o = block_enable_reg[MCB_BIT_LO_SINGLE_OSC];
  assign modulator_chain_enable_o = block_enable_reg[MCB_BIT_MOD_CHAIN];
  assign quad_divider_enable_o = block_enable_reg[MCB_BIT_QUAD_DIV];
  assign ext_lo_double_rate_driver_enable_o = block_enable_reg[MCB_BIT_EXT_LO_DOUBLE];
  assign ext_lo_single_rate_driver_enable_o = block_enable_reg[MCB_BIT_EXT_LO_SINGLE];
  // synthesizer support enables
  assign oscillator_mux_enable_o = block_enable_reg[MCB_BIT_OSC_MUX];
  assign reference_buffer_enable_o = block_enable_reg[MCB_BIT_REF_BUF];
  assign oscillator_enable_o = block_enable_reg[MCB_BIT_OSC];
  assign oscillator_divider_enable_o = block_enable_reg[MCB_BIT_OSC_DIV];
  assign charge_pump_enable_o = block_enable_reg[MCB_BIT_CHARGE_PUMP];
  assign oscillator_regulator_enable_o = block_enable_reg[MCB_BIT_OSC_REG];

  // checks on the register behaviour
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // a write frame ending into the soft reset word with bit 0 set
  sequence s_soft_write;
    wr_frame && (addr_reg == MCB_OFS_SOFT_RESET) && frame_data[MCB_SOFT_RESET_BIT];
  endsequence

  // a write frame ending into the soft reset word with bit 0 clear
  sequence s_soft_idle_write;
    wr_frame && (addr_reg == MCB_OFS_SOFT_RESET) && !frame_data[MCB_SOFT_RESET_BIT];
  endsequence

  // the read load cycle for a given address
  sequence s_load_soft;
    load_reg && (addr_reg == MCB_OFS_SOFT_RESET);
  endsequence

  sequence s_load_enable;
    load_reg && (addr_reg == MCB_OFS_BLOCK_ENABLE);
  endsequence

  // soft reset reads as zero
  chk_soft_read_zero: assert property (
    s_load_soft |=> (shout_reg == 16'h0000))
    else $error("soft reset word did not read back as zero");

  // bit 0 set fires the soft reset pulse
  chk_soft_bit_fires: assert property (
    s_soft_write |=> soft_rst_reg ##1 !soft_rst_reg)
    else $error("soft reset bit write did not give a one cycle pulse");

  // other bits alone do nothing
  chk_soft_bit_only: assert property (
    s_soft_idle_write |=> !soft_rst_reg && $stable(block_enable_reg))
    else $error("soft reset word acted without bit 0");

  // the pulse never lasts two cycles
  chk_soft_self_clear: assert property (
    soft_rst_reg |=> !soft_rst_reg)
    else $error("soft reset did not clear itself");

  // soft reset restores the block enable default
  chk_soft_restore: assert property (
    s_soft_write ##1 soft_rst_reg |=> (block_enable_reg == MCB_RST_BLOCK_ENABLE))
    else $error("block enable not restored by soft reset");

  // block enable takes the written word
  chk_enable_write: assert property (
    wr_enable |=> (block_enable_reg == $past(frame_data)))
    else $error("block enable did not take the written word");

  // block enable keeps its value between writes
  chk_enable_hold: assert property (
    !wr_enable && !soft_rst_reg |=> $stable(block_enable_reg))
    else $error("block enable changed without a write");

  // block enable reads back what it holds
  chk_enable_readback: assert property (
    s_load_enable |=> (shout_reg == $past(block_enable_reg)))
    else $error("block enable read back wrong");

  // lo paths come up off after soft reset
  chk_lo_paths_off: assert property (
    soft_rst_reg |=> !lo_single_rate_from_osc_enable_o && !ext_lo_double_rate_driver_enable_o
                     && !ext_lo_single_rate_driver_enable_o)
    else $error("lo path enable not off after soft reset");

  // modulator chain and quadrature divider come up on
  chk_chain_on: assert property (
    soft_rst_reg |=> modulator_chain_enable_o && quad_divider_enable_o)
    else $error("modulator chain or divider not on after soft reset");

  // synthesizer support blocks come up on
  chk_synth_on: assert property (
    soft_rst_reg |=> oscillator_mux_enable_o && reference_buffer_enable_o && oscillator_enable_o
                     && oscillator_divider_enable_o && charge_pump_enable_o
                     && oscillator_regulator_enable_o)
    else $error("support block enable not on after soft reset");

  // bits 11 and 10 of a written enable word reach their pins on the next cycle
  chk_enable_pins: assert property (
    wr_enable |=> (lo_single_rate_from_osc_enable_o == $past(frame_data[MCB_BIT_LO_SINGLE_OSC]))
                  && (modulator_chain_enable_o == $past(frame_data[MCB_BIT_MOD_CHAIN])))
    else $error("enable pins do not follow the written word");

endmodule // mcb_reg_bank
`default_nettype wire

//--- verilog/mcb_reg_mem.sv
// memory of the sixteen plain configuration registers with registered read data.
// assumes: one write and one read per cycle; clear_i reloads every default.
`timescale 1ns/1ns
`default_nettype none
module mcb_reg_mem import mcb_pkg::*; (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic clear_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [3:0] wr_idx_i,
  input wire logic [15:0] wr_data_i,
  // read port
  input wire logic rd_en_i,
  input wire logic [3:0] rd_idx_i,
  output logic [15:0] rd_data_o
);

  logic [15:0] mem_reg [MCB_MEM_DEPTH];
  logic [15:0] rd_data_reg;

  assign rd_data_o = rd_data_reg;

  // storage, reloaded with defaults on either reset
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || clear_i) begin
      for (int i = 0; i < MCB_MEM_DEPTH; i++) begin
        mem_reg[i] <= MCB_SLOT_RST[i];
      end
      rd_data_reg <= 16'h0000;
    end else begin
      if (wr_en_i) begin
        mem_reg[wr_idx_i] <= wr_data_i;
      end
      if (rd_en_i) begin
        rd_data_reg <= mem_reg[rd_idx_i];
      end
    end
  end

endmodule // mcb_reg_mem
`default_nettype wire

//--- verilog/mcb_spi_shift.sv
// serial port front end: sclk edge detection, bit counter and input shifter.
// assumes: pins synchronous to clk_sys_i, sclk idle low, each sclk half period
// at least four clk_sys_i cycles.
`timescale 1ns/1ns
`default_nettype none
module mcb_spi_shift import mcb_pkg::*; (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // serial pins
  input wire logic sclk_i,
  input wire logic csb_n_i,
  input wire logic sdio_i,
  // frame view
  output logic sclk_rise_o,
  output logic sclk_fall_o,
  output logic [4:0] bit_cnt_o,
  output logic [23:0] shift_o
);

  logic sclk_d_reg;
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic [23:0] sh_reg;
  logic [23:0] sh_next;
  logic take;

  // edges count only inside a frame; bits past the frame are dropped
  assign sclk_rise_o = sclk_i & ~sclk_d_reg & ~csb_n_i;
  assign sclk_fall_o = ~sclk_i & sclk_d_reg & ~csb_n_i;
  assign take = sclk_rise_o && (cnt_reg != MCB_CNT_FRAME_DONE);
  assign cnt_next = csb_n_i ? 5'h00 : (take ? 5'(cnt_reg + 5'h01) : cnt_reg);
  assign sh_next = take ? {sh_reg[22:0], sdio_i} : sh_reg;
  assign bit_cnt_o = cnt_reg;
  assign shift_o = sh_reg;

  // edge history, counter and shifter
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sclk_d_reg <= 1'b0;
      cnt_reg <= 5'h00;
      sh_reg <= 24'h000000;
    end else begin
      sclk_d_reg <= sclk_i;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
    end
  end

endmodule // mcb_spi_shift
`default_nettype wire
